// ### design/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Three stages; the level only moves once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule

// ### design/timeout_chain.sv
`timescale 1ns/1ps
module timeout_chain (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic advance_i,
  input wire logic clear_all_i,
  input wire logic clear_upper_i,
  input wire logic clear_pre_i,
  input wire logic long_sel_i,
  output logic overflow_o,
  output logic [wdog_pkg::CHAIN_W-1:0] chain_o
);
  import wdog_pkg::*;

  logic [CHAIN_W-1:0] chain_r;
  logic [CHAIN_W-1:0] limit;

  // Counter in the upper six bits, prescaler in the lower twelve
  assign chain_o = chain_r;
  assign limit = long_sel_i ? TIMEOUT_LONG - 18'h0_0001 : TIMEOUT_SHORT - 18'h0_0001;
  assign overflow_o = advance_i && (chain_r >= limit);

  // Clears take priority over counting so a late service always lands
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_all_i) begin
      chain_r <= '0;
    end else if (clear_upper_i) begin
      chain_r <= {{(CHAIN_W-KEEP_W){1'b0}}, chain_r[KEEP_W-1:0]};
    end else if (clear_pre_i) begin
      chain_r <= {chain_r[CHAIN_W-1:PRE_W], {PRE_W{1'b0}}};
    end else if (advance_i) begin
      chain_r <= chain_r + 18'h0_0001;
    end
  end
endmodule

// ### design/watchdog_unit.sv
`timescale 1ns/1ps
module watchdog_unit #(
  parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [wdog_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [wdog_pkg::DAT_W-1:0] dat_i,
  output logic [wdog_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  // CPU and system events, same clock
  input wire logic stop_exec_i,
  input wire logic stop_exit_i,
  input wire logic wait_mode_i,
  input wire logic vector_fetch_i,
  input wire logic internal_reset_i,
  input wire logic monitor_mode_i,
  input wire logic break_active_i,
  // Test voltage detectors on pins, asynchronous
  input wire logic hv_irq_pin_i,
  input wire logic hv_rst_pin_i,
  // Open-drain reset pin, reset request, stop status and interrupt
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic wdog_reset_o,
  output logic stopped_o,
  output logic irq_o
);
  import wdog_pkg::*;

  // Bus decode
  logic req;
  logic wr_req;
  logic rd_req;
  logic [15:0] idx;
  logic ack_r;
  logic [DAT_W-1:0] rd_nxt;

  // Software state
  cfg_t cfg_r;
  logic cause_r;
  events_t irq_status_r;
  events_t irq_mask_r;
  events_t evt;

  // Operating state
  state_t state_r;
  logic [PULSE_W-1:0] pulse_cnt_r;
  logic [POR_W-1:0] por_cnt_r;
  logic por_done_r;
  logic por_clear;

  // Synchronised pins and derived controls
  logic hv_irq;
  logic hv_rst;
  logic disabled;
  logic advance;
  logic overflow;
  logic service_wr;
  logic stop_take;
  logic clear_all;
  logic clear_pre;
  logic [CHAIN_W-1:0] chain;

  // Test voltage pins come from outside the clock domain
  pin_sync3 u_sync_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(hv_irq_pin_i),
    .level_o(hv_irq)
  );

  pin_sync3 u_sync_rst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(hv_rst_pin_i),
    .level_o(hv_rst)
  );

  // A request is taken on the edge where ack is not yet given
  assign req = cyc_i && stb_i && !ack_r;
  assign wr_req = req && we_i;
  assign rd_req = req && !we_i;
  assign idx = adr_i[ADR_W-1:IDX_LSB];
  assign ack_o = ack_r;

  // Single-cycle acknowledge; every address answers, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Any write to the service location counts, whatever the data or lanes
  assign service_wr = wr_req && (idx == IDX_SERVICE);

  // Disable sources: software bit, monitor mode with either test voltage, or break with reset-pin test voltage
  assign disabled = cfg_r.watchdog_disable_bit
    || (monitor_mode_i && (hv_irq || hv_rst))
    || (break_active_i && hv_rst);

  // Stop only takes effect when software has set stop_enable
  assign stop_take = stop_exec_i && cfg_r.stop_enable;

  // Counting runs in run and wait alike; wait_mode_i does not gate it
  assign advance = (state_r == ST_RUN) && !disabled;

  // Whole chain cleared by any internal reset, including our own
  assign clear_all = internal_reset_i || (state_r == ST_PULSE) || disabled;

  // Prescaler-only clears
  assign clear_pre = stop_take
    || vector_fetch_i
    || por_clear;

  timeout_chain u_chain (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(advance),
    .clear_all_i(clear_all),
    .clear_upper_i(service_wr),
    .clear_pre_i(clear_pre),
    .long_sel_i(cfg_r.timeout_rate_select),
    .overflow_o(overflow),
    .chain_o(chain)
  );

  // Power-up delay counter fires a single prescaler clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_cnt_r <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r <= por_cnt_r + 13'h0001;
      if (por_cnt_r == POR_W'(POR_CLEAR_CYC - 1)) begin
        por_done_r <= 1'b1;
      end
    end
  end
  assign por_clear = !por_done_r && (por_cnt_r == POR_W'(POR_CLEAR_CYC - 1));

  // Run, stopped, or driving the reset pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
      pulse_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (overflow) begin
            state_r <= ST_PULSE;
            pulse_cnt_r <= '0;
          end else if (stop_take) begin
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          // Oscillator gated off: the chain holds until wake-up
          if (stop_exit_i) begin
            state_r <= ST_RUN;
          end
        end
        ST_PULSE: begin
          pulse_cnt_r <= pulse_cnt_r + 6'h01;
          if (pulse_cnt_r == PULSE_W'(RST_PULSE_CYC - 1)) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // Reset pin is only ever pulled low; released it floats high
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = (state_r == ST_PULSE);
  assign wdog_reset_o = (state_r == ST_PULSE);
  assign stopped_o = (state_r == ST_STOP);

  // Configuration register, low byte lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RESET;
    end else if (wr_req && (idx == IDX_CONFIG) && sel_i[0]) begin
      cfg_r <= dat_i[2:0];
    end
  end

  // Cause bit: set on overflow, write one to clear; the set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= 1'b0;
    end else if (overflow) begin
      cause_r <= 1'b1;
    end else if (wr_req && (idx == IDX_CAUSE) && sel_i[0] && dat_i[0]) begin
      cause_r <= 1'b0;
    end
  end

  // Housekeeping events only; overflow is kept off the interrupt line
  assign evt.serviced = service_wr;
  assign evt.vector_clear = vector_fetch_i;
  assign evt.stop_clear = stop_take;

  // Sticky status: events set, write one clears, a same-cycle event stays
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= EVT_RESET;
    end else if (wr_req && (idx == IDX_IRQ_STATUS) && sel_i[0]) begin
      irq_status_r <= (irq_status_r & ~events_t'(dat_i[2:0])) | evt;
    end else begin
      irq_status_r <= irq_status_r | evt;
    end
  end

  // Interrupt mask of the same layout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= EVT_RESET;
    end else if (wr_req && (idx == IDX_IRQ_MASK) && sel_i[0]) begin
      irq_mask_r <= dat_i[2:0];
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  // Read mux; the service location never exposes watchdog state
  always_comb begin
    rd_nxt = RD_UNMAPPED;
    unique case (idx)
      IDX_SERVICE: rd_nxt = {24'h00_0000, RESET_VECTOR_LO};
      IDX_CONFIG: rd_nxt = {29'h0000_0000, cfg_r};
      IDX_CAUSE: rd_nxt = {31'h0000_0000, cause_r};
      IDX_IRQ_STATUS: rd_nxt = {29'h0000_0000, irq_status_r};
      IDX_IRQ_MASK: rd_nxt = {29'h0000_0000, irq_mask_r};
      IDX_COUNT: rd_nxt = {14'h0000, chain};
      default: rd_nxt = RD_UNMAPPED;
    endcase
  end

  // Read data registered with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= RD_UNMAPPED;
    end else if (rd_req) begin
      dat_o <= rd_nxt;
    end
  end

  // The software side keeps the chain from overflowing; wait_mode_i
  // is accepted only for visibility and changes nothing.
  logic unused_wait;
  assign unused_wait = wait_mode_i;
endmodule

// ### pkg/wdog_pkg.sv
package wdog_pkg;

  // Word indices on the register bus; byte address is four times the index
  localparam logic [15:0] IDX_SERVICE = 16'hffff;
  localparam logic [15:0] IDX_CONFIG = 16'h0000;
  localparam logic [15:0] IDX_CAUSE = 16'h0001;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h0002;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0003;
  localparam logic [15:0] IDX_COUNT = 16'h0004;

  // Bus geometry
  localparam int ADR_W = 18;
  localparam int IDX_LSB = 2;
  localparam int DAT_W = 32;

  // Counter geometry: 12-bit prescaler below a 6-bit counter
  localparam int PRE_W = 12;
  localparam int CNT_W = 6;
  localparam int CHAIN_W = PRE_W + CNT_W;
  localparam int KEEP_W = 4;

  // Timeout lengths in oscillator cycles from a full clear
  localparam logic [CHAIN_W-1:0] TIMEOUT_SHORT = 18'h0_1ff0;
  localparam logic [CHAIN_W-1:0] TIMEOUT_LONG = 18'h3_fff0;

  // Reset pin pulse length and power-up prescaler clear delay, in cycles
  localparam int RST_PULSE_CYC = 32;
  localparam int POR_CLEAR_CYC = 4096;
  localparam int PULSE_W = 6;
  localparam int POR_W = 13;

  // Reset values
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Software-set configuration bits
  typedef struct packed {
    logic stop_enable;
    logic watchdog_disable_bit;
    logic timeout_rate_select;
  } cfg_t;

  // Events that set sticky interrupt status bits
  typedef struct packed {
    logic stop_clear;
    logic vector_clear;
    logic serviced;
  } events_t;

  // Operating state of the unit
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_PULSE = 2'b10
  } state_t;

endpackage

// ### verif/reset_pin_model.sv
`timescale 1ns/1ps
// Board side of the reset pin: open drain with a pull-up, so a released pin reads high
module reset_pin_model (
  input wire logic drive_i,
  input wire logic oe_i,
  output logic level_o
);
  assign level_o = oe_i ? drive_i : 1'b1;
endmodule

// ### verif/watchdog_timeout_reset_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module watchdog_timeout_reset_test;
  import wdog_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, stop_exec_i, stop_exit_i, wait_mode_i;
  logic vector_fetch_i, internal_reset_i, monitor_mode_i, break_active_i, hv_irq_pin_i;
  logic hv_rst_pin_i, rst_pin_o, rst_pin_oe_o, wdog_reset_o, stopped_o, irq_o, pin_lvl;
  logic [ADR_W-1:0] adr_i;
  logic [3:0] sel_i;
  logic [DAT_W-1:0] dat_i, dat_o, q;
  int err_count, check_count, n;
  int pulses = 0;
  int mark;
  watchdog_unit #(.RESET_VECTOR_LO(8'ha5)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .stop_exec_i(stop_exec_i), .stop_exit_i(stop_exit_i),
    .wait_mode_i(wait_mode_i), .vector_fetch_i(vector_fetch_i),
    .internal_reset_i(internal_reset_i), .monitor_mode_i(monitor_mode_i),
    .break_active_i(break_active_i), .hv_irq_pin_i(hv_irq_pin_i), .hv_rst_pin_i(hv_rst_pin_i),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .wdog_reset_o(wdog_reset_o),
    .stopped_o(stopped_o), .irq_o(irq_o));
  reset_pin_model u_pin (.drive_i(rst_pin_o), .oe_i(rst_pin_oe_o), .level_o(pin_lvl));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Running count of pulse cycles, so quiet stretches need no polling
  always @(posedge clk_i) if (rst_pin_oe_o === 1'b1) pulses <= pulses + 1;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One classic cycle; the request stands until ack is sampled
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                    output logic [31:0] r);
    int k;
    k = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, idx, 2'b00, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    r = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    @(posedge clk_i);
    if (k >= 50) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // One-cycle event: 0 stop, 1 stop end, 2 vector fetch, 3 internal reset
  task automatic ev(input int k);
    {internal_reset_i, vector_fetch_i, stop_exit_i, stop_exec_i} <= 4'h1 << k;
    @(posedge clk_i);
    {internal_reset_i, vector_fetch_i, stop_exit_i, stop_exec_i} <= 4'h0;
    @(posedge clk_i);
  endtask
  initial begin
    {cyc_i, stb_i, we_i, stop_exec_i, stop_exit_i, vector_fetch_i, internal_reset_i} = '0;
    {wait_mode_i, monitor_mode_i, break_active_i, hv_irq_pin_i, hv_rst_pin_i} = '0;
    {adr_i, dat_i, err_count, check_count} = '0;
    sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, IDX_CONFIG, 0, q);
    `CHK(q, 32'h0000_0000)
    wb(0, IDX_SERVICE, 0, q);
    `CHK(q, 32'h0000_00a5)
    wb(0, 16'h0040, 0, q);
    `CHK(q, RD_UNMAPPED)
    // Power-up clear lands mid-count; without it the chain would be past 4095
    repeat (4100) @(posedge clk_i);
    wb(0, IDX_COUNT, 0, q);
    `CHK(q[31:8], 24'h00_0000)
    $display("reset values done");
    // Short timeout from a full clear, with wait mode on
    wait_mode_i <= 1'b1;
    ev(3);
    n = 0;
    while (rst_pin_oe_o !== 1'b1 && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n, TIMEOUT_SHORT)
    if (n >= 9000) begin
      err_count++;
      tally_and_finish();
    end
    n = 0;
    while (pin_lvl === 1'b0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n, RST_PULSE_CYC)
    if (n >= 40) begin
      err_count++;
      tally_and_finish();
    end
    wb(0, IDX_CAUSE, 0, q);
    `CHK(q, 32'h0000_0001)
    wb(0, IDX_IRQ_STATUS, 0, q);
    `CHK(q, 32'h0000_0000)
    $display("timeout done");
    mark = pulses;
    repeat (3) begin
      repeat (4000) @(posedge clk_i);
      wb(1, IDX_SERVICE, 32'h0000_005c, q);
    end
    `CHK(pulses, mark)
    wait_mode_i <= 1'b0;
    $display("service done");
    // Long select, disable bit, monitor with either pin, break with reset pin
    for (int i = 0; i < 5; i++) begin
      wb(1, IDX_CONFIG, (i == 0) ? 1 : (i == 1) ? 2 : 0, q);
      monitor_mode_i <= (i == 2 || i == 3);
      hv_irq_pin_i <= (i == 2);
      hv_rst_pin_i <= (i > 2);
      break_active_i <= (i == 4);
      ev(3);
      mark = pulses;
      repeat (8300) @(posedge clk_i);
      `CHK(pulses, mark)
    end
    {monitor_mode_i, hv_irq_pin_i, hv_rst_pin_i, break_active_i} <= 4'h0;
    $display("disable done");
    ev(0);
    `CHK(stopped_o, 1'b0)
    wb(1, IDX_CONFIG, 4, q);
    repeat (100) @(posedge clk_i);
    ev(2);
    wb(0, IDX_COUNT, 0, q);
    `CHK(q[31:4], 28'h000_0000)
    repeat (100) @(posedge clk_i);
    ev(0);
    `CHK(stopped_o, 1'b1)
    wb(0, IDX_COUNT, 0, q);
    `CHK(q, 32'h0000_0000)
    mark = pulses;
    repeat (9000) @(posedge clk_i);
    `CHK(pulses, mark)
    ev(1);
    `CHK(stopped_o, 1'b0)
    $display("stop done");
    // Sticky status, mask and write-one-to-clear
    wb(1, IDX_IRQ_STATUS, 7, q);
    wb(1, IDX_IRQ_MASK, 1, q);
    wb(1, IDX_SERVICE, 0, q);
    `CHK(irq_o, 1'b1)
    ev(2);
    wb(0, IDX_IRQ_STATUS, 0, q);
    `CHK(q, 32'h0000_0003)
    wb(1, IDX_IRQ_STATUS, 1, q);
    `CHK(irq_o, 1'b0)
    $display("interrupt done");
    tally_and_finish();
  end
endmodule

// ### verif/watchdog_unit_sva.sv
`timescale 1ns/1ps
module watchdog_unit_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_o,
  input wire logic wdog_reset_o,
  input wire logic stopped_o,
  input wire logic stop_exec_i,
  input wire logic stop_exit_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] hold_r;
  // Cycles the pin has been pulled so far; cleared whenever it is released
  always_ff @(posedge clk_i) begin
    if (rst_i || !rst_pin_oe_o) begin
      hold_r <= 6'h00;
    end else begin
      hold_r <= hold_r + 6'h01;
    end
  end
  bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered in the next cycle");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  pulse_len_a: assert property ($fell(rst_pin_oe_o) |-> hold_r == 6'h20)
    else $error("reset pin pulse not 32 cycles");
  pulse_max_a: assert property (hold_r <= 6'h20)
    else $error("reset pin pulse too long");
  pin_low_a: assert property (rst_pin_oe_o |-> !rst_pin_o && wdog_reset_o)
    else $error("reset pin not pulled low with request");
  req_match_a: assert property (!rst_pin_oe_o |-> !wdog_reset_o)
    else $error("reset request without pin pulse");
  no_irq_a: assert property ($rose(rst_pin_oe_o) |-> $stable(irq_o))
    else $error("overflow touched the interrupt line");
  stop_quiet_a: assert property (stopped_o |-> !$rose(rst_pin_oe_o))
    else $error("overflow while stopped");
  stop_cause_a: assert property ($rose(stopped_o) |-> $past(stop_exec_i))
    else $error("stop entered without stop instruction");
  stop_end_a: assert property (stopped_o && stop_exit_i |-> ##[1:2] !stopped_o)
    else $error("stop mode did not end");
  cover property ($rose(rst_pin_oe_o));
  cover property ($rose(stopped_o));
  cover property ($rose(irq_o));
endmodule
bind watchdog_unit watchdog_unit_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
  .wdog_reset_o(wdog_reset_o), .stopped_o(stopped_o), .stop_exec_i(stop_exec_i),
  .stop_exit_i(stop_exit_i), .irq_o(irq_o));
